/* pcfr_consts.vh */
// Register map, reset values, field positions and timing counts
`ifndef PCFR_CONSTS_VH
`define PCFR_CONSTS_VH

// ==========================================================
// Register indexes
`define PCFR_IDX_ILIM       2'h0
`define PCFR_IDX_THRESH     2'h1
`define PCFR_IDX_FMODE      2'h2
`define PCFR_IDX_FLAGS      2'h3

// ==========================================================
// Reset values
`define PCFR_RST_ILIM       8'h1B
`define PCFR_RST_THRESH     8'h08
`define PCFR_RST_FMODE      8'h43

// ==========================================================
// Field positions
`define PCFR_SLOPE_HI       7
`define PCFR_SLOPE_LO       5
`define PCFR_TCE_BIT        4
`define PCFR_ILIM_HI        3
`define PCFR_ILIM_LO        0
`define PCFR_ILIM_MAX       4'hB
`define PCFR_GOOD_WINDOW_LOW_SEL_BIT       4
`define PCFR_OVL_HI         3
`define PCFR_OVL_LO         2
`define PCFR_UVL_HI         1
`define PCFR_UVL_LO         0
`define PCFR_THRESH_MASK    8'h1F
`define PCFR_TRE_BIT        7
`define PCFR_PVE_BIT        6
`define PCFR_LSEL_HI        5
`define PCFR_LSEL_LO        1
`define PCFR_PVL_BIT        0

// ==========================================================
// Fault vector order: 0 OV, 1 UV, 2 OC, 3 OT, 4 TR
`define PCFR_NFLT           5
`define PCFR_F_OV           0
`define PCFR_F_UV           1
`define PCFR_FAST_MASK      5'h15

// ==========================================================
// Threshold percentages and floor
`define PCFR_PCT_OV0        8'h6E
`define PCFR_PCT_OV1        8'h78
`define PCFR_PCT_OV2        8'h82
`define PCFR_PCT_UV0        8'h4B
`define PCFR_PCT_UV1        8'h50
`define PCFR_PCT_UV2        8'h55
`define PCFR_PCT_UV3        8'h5A
`define PCFR_PCT_PGL0       8'h5A
`define PCFR_PCT_PGL1       8'h5F
`define PCFR_PCT_PGH        8'h6E
`define PCFR_PCT_DIV        20'h00064
`define PCFR_OV_FLOOR_MV    12'h3E8

// ==========================================================
// Timing
`define PCFR_CLK_KHZ        25000
`define PCFR_RETRY_MS       130
`define PCFR_RETRY_CYC      (`PCFR_RETRY_MS * `PCFR_CLK_KHZ)

`endif

/* pcfr_thresh_calc.v */
// Absolute protection and good-window thresholds from the setpoint
`timescale 1ns/1ps
`include "pcfr_consts.vh"

module pcfr_thresh_calc #(
   parameter MVW = 12
) (
   input  wire           ref_clk,     // System clock
   input  wire           rst_n,       // Async reset, active low
   input  wire [MVW-1:0] setpoint_mv, // Output setpoint, mV
   input  wire [1:0]     ov_code,     // Overvoltage level code
   input  wire [1:0]     uv_code,     // Undervoltage level code
   input  wire           pg_low_sel,  // Good window low select
   output reg  [MVW-1:0] ovp_mv_r,    // Overvoltage threshold
   output reg  [MVW-1:0] uvp_mv_r,    // Undervoltage threshold
   output reg  [MVW-1:0] pgl_mv_r,    // Good window low limit
   output reg  [MVW-1:0] pgh_mv_r     // Good window high limit
);

   reg  [7:0]     ov_pct;
   reg  [7:0]     uv_pct;
   wire [7:0]     pgl_pct;
   wire [MVW+7:0] ov_full;
   wire [MVW+7:0] uv_full;
   wire [MVW+7:0] pgl_full;
   wire [MVW+7:0] pgh_full;
   wire [MVW-1:0] ov_raw;

   always @* begin
      case (ov_code)
         2'h0:    ov_pct = `PCFR_PCT_OV0;
         2'h1:    ov_pct = `PCFR_PCT_OV1;
         default: ov_pct = `PCFR_PCT_OV2;
      endcase
      case (uv_code)
         2'h0:    uv_pct = `PCFR_PCT_UV0;
         2'h1:    uv_pct = `PCFR_PCT_UV1;
         2'h2:    uv_pct = `PCFR_PCT_UV2;
         default: uv_pct = `PCFR_PCT_UV3;
      endcase
   end

   assign pgl_pct  = pg_low_sel ? `PCFR_PCT_PGL1 : `PCFR_PCT_PGL0;
   assign ov_full  = ({8'h00, setpoint_mv} * ov_pct) / `PCFR_PCT_DIV;
   assign uv_full  = ({8'h00, setpoint_mv} * uv_pct) / `PCFR_PCT_DIV;
   assign pgl_full = ({8'h00, setpoint_mv} * pgl_pct) / `PCFR_PCT_DIV;
   assign pgh_full = ({8'h00, setpoint_mv} * `PCFR_PCT_PGH) / `PCFR_PCT_DIV;
   assign ov_raw   = ov_full[MVW-1:0];

   // Recomputed every cycle so margining moves all levels at once
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovp_mv_r <= {MVW{1'b0}};
         uvp_mv_r <= {MVW{1'b0}};
         pgl_mv_r <= {MVW{1'b0}};
         pgh_mv_r <= {MVW{1'b0}};
      end else begin
         ovp_mv_r <= (ov_raw < `PCFR_OV_FLOOR_MV) ? `PCFR_OV_FLOOR_MV : ov_raw;
         uvp_mv_r <= uv_full[MVW-1:0];
         pgl_mv_r <= pgl_full[MVW-1:0];
         pgh_mv_r <= pgh_full[MVW-1:0];
      end
   end

endmodule // pcfr_thresh_calc

/* pcfr_retry_timer.v */
// One-shot interval timer for restart and re-enable spacing
`timescale 1ns/1ps

module pcfr_retry_timer #(
   parameter CW  = 22,
   parameter CYC = 3250000
) (
   input  wire ref_clk,  // System clock
   input  wire rst_n,    // Async reset, active low
   input  wire start,    // Restart the interval
   output reg  done_r    // Interval elapsed, held until start
);

   localparam integer  LOAD_I = CYC - 1;
   localparam [CW-1:0] LOAD   = LOAD_I[CW-1:0];

   reg [CW-1:0] cnt_r;
   reg          run_r;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= {CW{1'b0}};
         run_r  <= 1'b0;
         done_r <= 1'b0;
      end else if (start) begin
         cnt_r  <= LOAD;
         run_r  <= 1'b1;
         done_r <= 1'b0;
      end else if (run_r) begin
         if (cnt_r == {CW{1'b0}}) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule // pcfr_retry_timer

/* pcfr_top.v */
// Protection configuration registers and fault restart control
//
// Notes on behaviour
// - Slope code bits 7:5, default 000
// - Bit 4 enables temperature compensation, default on
// - Current limit codes above Bh read as Bh
// - Threshold bit 4 picks 95 or 90 percent
// - Overvoltage code: 110, 120, 130, 130 percent
// - Undervoltage code: 75, 80, 85, 90 percent
// - Thresholds follow every setpoint change
// - Fault mode bit 7 enables tracking fault
// - Fault mode bit 5 latches tracking fault
// - Bits 4..1 latch OT, OC, UV, OV
// - Non-latching: retry every 130 ms
// - Every restart ramps, never jumps
// - Latching: output stays off, no retry
// - Re-enable needs 130 ms and cleared cause
// - Clear flag, recycle turn-on, or power cycle
// - Tripped protection drives its flag to 0
// - Overvoltage threshold never below 1.0 V
// - Good window upper limit fixed 110 percent
`timescale 1ns/1ps
`include "pcfr_consts.vh"

module pcfr_top #(
   parameter MVW       = 12,
   parameter RETRY_CYC = `PCFR_RETRY_CYC
) (
   input  wire           ref_clk,           // 25 MHz clock
   input  wire           rst_n,             // Async reset, active low
   input  wire           reg_wr,            // Register write strobe
   input  wire [1:0]     reg_addr,          // Register index
   input  wire [7:0]     reg_wdata,         // Write data
   output wire [7:0]     reg_rdata,         // Read data, registered
   input  wire [MVW-1:0] setpoint_mv,       // Output setpoint, mV
   input  wire           turn_on_cmd,       // Turn-on command level
   input  wire           ramp_done,         // Ramp reached setpoint
   input  wire           ov_det,            // Overvoltage comparator
   input  wire           uv_det,            // Undervoltage comparator
   input  wire           oc_det,            // Overcurrent comparator
   input  wire           ot_det,            // Overtemperature sensor
   input  wire           tr_det,            // Tracking error comparator
   input  wire [4:0]     flag_clr,          // Flag clear pulses
   output wire           out_enable,        // Power stage on
   output wire           ramp_req,          // Ramp under track/seq
   output wire           fast_off,          // Instant switch turn-off
   output wire           low_side_on,       // Low side clamp on
   output wire [2:0]     load_line_slope,   // Slope code
   output wire           temp_comp_enable,  // Current limit comp
   output wire [3:0]     current_limit_setpoint, // Limit code
   output wire [7:0]     protection_flags,  // Status, active low
   output wire [MVW-1:0] ovp_thresh_mv,     // Overvoltage level
   output wire [MVW-1:0] uvp_thresh_mv,     // Undervoltage level
   output wire [MVW-1:0] pg_low_mv,         // Good window low
   output wire [MVW-1:0] pg_high_mv         // Good window high
);

   localparam NF = `PCFR_NFLT;

   // ==========================================================
   // States
   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_RAMP  = 5'h02;
   localparam [4:0] S_RUN   = 5'h04;
   localparam [4:0] S_RETRY = 5'h08;
   localparam [4:0] S_LATCH = 5'h10;

   reg  [4:0]    state_r;
   reg  [4:0]    state_nxt;
   reg  [7:0]    ilim_reg_r;
   reg  [7:0]    thresh_reg_r;
   reg  [7:0]    fault_mode_reg_r;
   reg  [NF-1:0] flag_r;
   reg  [NF-1:0] src_r;
   reg  [NF-1:0] src_nxt;
   reg           seen_off_r;
   reg           seen_off_nxt;
   reg  [7:0]    rdata_r;
   reg  [7:0]    rdata_nxt;
   reg           out_en_r;
   reg           ramp_req_r;
   reg           fast_off_r;
   reg           fast_off_nxt;
   reg           low_side_r;
   reg           low_side_nxt;
   reg  [7:0]    flags_out_r;
   reg           tmr_start;
   reg  [3:0]    ilim_wr;

   wire          active;
   wire          in_ramp;
   wire          in_run;
   wire [NF-1:0] raw;
   wire [NF-1:0] cond;
   wire [NF-1:0] latch_sel;
   wire          trip;
   wire          trip_latch;
   wire          cause_gone;
   wire          flags_back;
   wire          rearm;
   wire          tmr_done;

   // ==========================================================
   // Register writes
   always @* begin
      ilim_wr = reg_wdata[`PCFR_ILIM_HI:`PCFR_ILIM_LO];
      if (ilim_wr > `PCFR_ILIM_MAX)
         ilim_wr = `PCFR_ILIM_MAX;
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ilim_reg_r       <= `PCFR_RST_ILIM;
         thresh_reg_r     <= `PCFR_RST_THRESH;
         fault_mode_reg_r <= `PCFR_RST_FMODE;
      end else if (reg_wr) begin
         case (reg_addr)
            `PCFR_IDX_ILIM:
               ilim_reg_r <= {reg_wdata[`PCFR_SLOPE_HI:`PCFR_TCE_BIT], ilim_wr};
            `PCFR_IDX_THRESH:
               thresh_reg_r <= reg_wdata & `PCFR_THRESH_MASK;
            `PCFR_IDX_FMODE:
               fault_mode_reg_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read mux, registered
   always @* begin
      case (reg_addr)
         `PCFR_IDX_ILIM:   rdata_nxt = ilim_reg_r;
         `PCFR_IDX_THRESH: rdata_nxt = thresh_reg_r;
         `PCFR_IDX_FMODE:  rdata_nxt = fault_mode_reg_r;
         default:          rdata_nxt = flags_out_r;
      endcase
   end

   // ==========================================================
   // Fault qualification
   assign in_ramp = state_r[1];
   assign in_run  = state_r[2];
   assign active  = in_ramp | in_run;
   assign raw     = {tr_det, ot_det, oc_det, uv_det, ov_det};

   // UV only in steady state, tracking only while ramping up
   assign cond[`PCFR_F_OV] = ov_det & active;
   assign cond[`PCFR_F_UV] = uv_det & in_run;
   assign cond[2]          = oc_det & active;
   assign cond[3]          = ot_det & active;
   assign cond[4]          = tr_det & in_ramp
                             & fault_mode_reg_r[`PCFR_TRE_BIT];

   // Phase error has no detector; its enable and mode bits only store
   assign latch_sel  = fault_mode_reg_r[`PCFR_LSEL_HI:`PCFR_LSEL_LO];
   assign trip       = |cond;
   assign trip_latch = |(cond & latch_sel);

   // Re-enable qualifiers
   assign cause_gone = ~|(src_r & raw);
   assign flags_back = &(flag_r | ~src_r);
   assign rearm      = tmr_done & cause_gone
                       & (flags_back | (seen_off_r & turn_on_cmd));

   // ==========================================================
   // Status flags, trip beats a same-cycle clear
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi = gi + 1) begin : g_flag
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n)
               flag_r[gi] <= 1'b1;
            else if (cond[gi])
               flag_r[gi] <= 1'b0;
            else if (flag_clr[gi])
               flag_r[gi] <= 1'b1;
         end
      end
   endgenerate

   // ==========================================================
   // Restart sequencer
   always @* begin
      state_nxt    = state_r;
      src_nxt      = src_r;
      seen_off_nxt = seen_off_r;
      tmr_start    = 1'b0;
      fast_off_nxt = fast_off_r;
      low_side_nxt = low_side_r;
      case (state_r)
         S_IDLE: begin
            fast_off_nxt = 1'b0;
            low_side_nxt = 1'b0;
            if (turn_on_cmd)
               state_nxt = S_RAMP;
         end
         S_RAMP, S_RUN: begin
            if (trip) begin
               src_nxt      = cond;
               seen_off_nxt = 1'b0;
               tmr_start    = 1'b1;
               fast_off_nxt = |(cond & `PCFR_FAST_MASK);
               low_side_nxt = cond[`PCFR_F_OV];
               state_nxt    = trip_latch ? S_LATCH : S_RETRY;
            end else if (!turn_on_cmd) begin
               state_nxt = S_IDLE;
            end else if (in_ramp && ramp_done) begin
               state_nxt = S_RUN;
            end
         end
         S_RETRY: begin
            if (!turn_on_cmd) begin
               state_nxt = S_IDLE;
            end else if (tmr_done) begin
               fast_off_nxt = 1'b0;
               low_side_nxt = 1'b0;
               state_nxt    = S_RAMP;
            end
         end
         S_LATCH: begin
            if (!turn_on_cmd)
               seen_off_nxt = 1'b1;
            if (rearm && turn_on_cmd) begin
               fast_off_nxt = 1'b0;
               low_side_nxt = 1'b0;
               state_nxt    = S_RAMP;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= S_IDLE;
         src_r       <= {NF{1'b0}};
         seen_off_r  <= 1'b0;
         out_en_r    <= 1'b0;
         ramp_req_r  <= 1'b0;
         fast_off_r  <= 1'b0;
         low_side_r  <= 1'b0;
         rdata_r     <= 8'h00;
         flags_out_r <= 8'hFF;
      end else begin
         state_r     <= state_nxt;
         src_r       <= src_nxt;
         seen_off_r  <= seen_off_nxt;
         out_en_r    <= state_nxt[1] | state_nxt[2];
         ramp_req_r  <= state_nxt[1];
         fast_off_r  <= fast_off_nxt;
         low_side_r  <= low_side_nxt;
         rdata_r     <= rdata_nxt;
         flags_out_r <= {2'h3, flag_r[4], flag_r[3], flag_r[2],
                         flag_r[1], flag_r[0], 1'b1};
      end
   end

   // ==========================================================
   // Interval timer and threshold arithmetic
   pcfr_retry_timer #(
      .CW  (22),
      .CYC (RETRY_CYC)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (tmr_start),
      .done_r  (tmr_done)
   );

   pcfr_thresh_calc #(
      .MVW (MVW)
   ) u_thresh (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .setpoint_mv (setpoint_mv),
      .ov_code     (thresh_reg_r[`PCFR_OVL_HI:`PCFR_OVL_LO]),
      .uv_code     (thresh_reg_r[`PCFR_UVL_HI:`PCFR_UVL_LO]),
      .pg_low_sel  (thresh_reg_r[`PCFR_GOOD_WINDOW_LOW_SEL_BIT]),
      .ovp_mv_r    (ovp_thresh_mv),
      .uvp_mv_r    (uvp_thresh_mv),
      .pgl_mv_r    (pg_low_mv),
      .pgh_mv_r    (pg_high_mv)
   );

   // ==========================================================
   // Outputs
   assign reg_rdata              = rdata_r;
   assign out_enable             = out_en_r;
   assign ramp_req               = ramp_req_r;
   assign fast_off               = fast_off_r;
   assign low_side_on            = low_side_r;
   assign load_line_slope        = ilim_reg_r[`PCFR_SLOPE_HI:`PCFR_SLOPE_LO];
   assign temp_comp_enable       = ilim_reg_r[`PCFR_TCE_BIT];
   assign current_limit_setpoint = ilim_reg_r[`PCFR_ILIM_HI:`PCFR_ILIM_LO];
   assign protection_flags       = flags_out_r;

endmodule // pcfr_top

/* pcfr_chk_sva.sv */
// Assertion checker for the protection configuration block
`timescale 1ns/1ps
module pcfr_chk #(
   parameter MVW = 12
) (
   input logic           ref_clk,                // Clock
   input logic           rst_n,                  // Reset, active low
   input logic           reg_wr,                 // Write strobe
   input logic [1:0]     reg_addr,               // Register index
   input logic [7:0]     reg_wdata,              // Write data
   input logic [7:0]     reg_rdata,              // Read data
   input logic [MVW-1:0] setpoint_mv,            // Setpoint
   input logic           turn_on_cmd,            // Turn-on level
   input logic           ov_det,                 // Overvoltage seen
   input logic           oc_det,                 // Overcurrent seen
   input logic           out_enable,             // Stage on
   input logic           fast_off,               // Instant off
   input logic           low_side_on,            // Low side clamp
   input logic [3:0]     current_limit_setpoint, // Limit code
   input logic [7:0]     protection_flags,       // Status, active low
   input logic [MVW-1:0] ovp_thresh_mv,          // OV threshold
   input logic [MVW-1:0] pg_high_mv              // Window high
);
   logic [MVW+7:0] pgh_w;
   // Expected upper window, 110 percent truncated
   assign pgh_w = (setpoint_mv * 8'h6E) / 8'h64;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Properties
   property p_ilim_sat;
      reg_wr && reg_addr == 2'h0 && reg_wdata[3:0] > 4'hB |=> current_limit_setpoint == 4'hB;
   endproperty
   a_ilim_sat: assert property (p_ilim_sat) else $error("limit code not saturated");
   property p_thr_rd;
      reg_wr && reg_addr == 2'h1 ##1 reg_addr == 2'h1 && !reg_wr
         |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F);
   endproperty
   a_thr_rd: assert property (p_thr_rd) else $error("threshold readback wrong");
   property p_pgh;
      $past(rst_n) |-> pg_high_mv == $past(pgh_w[MVW-1:0]);
   endproperty
   a_pgh: assert property (p_pgh) else $error("window high not 110 percent");
   property p_ov_floor;
      $past(rst_n) |-> ovp_thresh_mv >= 12'h3E8;
   endproperty
   a_ov_floor: assert property (p_ov_floor) else $error("OV threshold below floor");
   // Status word is registered from the flag bits, so it trails the turn-off by one edge
   property p_oc_trip;
      out_enable && oc_det |=> !out_enable && fast_off ##1 !protection_flags[3];
   endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("overcurrent trip missed");
   property p_ov_trip;
      out_enable && ov_det |=> !out_enable && low_side_on ##1 !protection_flags[1];
   endproperty
   a_ov_trip: assert property (p_ov_trip) else $error("overvoltage trip missed");
   property p_fixed_bits;
      protection_flags[7:6] == 2'b11 && protection_flags[0];
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("inactive flag bits low");
   property p_hold_off;
      $fell(out_enable) && turn_on_cmd |-> !out_enable [*8];
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("restart too early");
   c_oc: cover property (out_enable && oc_det);
   c_ov: cover property (out_enable && ov_det);
   c_on: cover property ($rose(out_enable));
endmodule // pcfr_chk

/* pcfr_stage_model.sv */
// Power stage model answering ramp requests
`timescale 1ns/1ps
module pcfr_stage_model (
   input  logic ref_clk,   // Clock
   input  logic rst_n,     // Reset, active low
   input  logic ramp_req,  // Ramp requested
   input  logic slow,      // Long ramp
   output logic ramp_done  // Ramp reached setpoint
);
   logic [3:0] cnt_r;
   // A real ramp takes time, so a restart is never a step
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || !ramp_req) begin
         cnt_r     <= 4'h0;
         ramp_done <= 1'b0;
      end else begin
         cnt_r     <= cnt_r + 4'h1;
         ramp_done <= cnt_r >= (slow ? 4'hC : 4'h2);
      end
   end
endmodule // pcfr_stage_model

/* pcfr_tb.sv */
// Self-checking testbench for the protection configuration block
`timescale 1ns/1ps
module testbench;
   localparam MVW = 12;
   localparam RC  = 20;
   logic           ref_clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           reg_wr = 1'b0;
   logic [1:0]     reg_addr = 2'h0;
   logic [7:0]     reg_wdata = 8'h00;
   logic [MVW-1:0] setpoint_mv = 12'h4B0;
   logic           turn_on_cmd = 1'b0;
   logic           ov_det = 1'b0;
   logic           uv_det = 1'b0;
   logic           oc_det = 1'b0;
   logic           ot_det = 1'b0;
   logic           tr_det = 1'b0;
   logic [4:0]     flag_clr = 5'h00;
   logic           slow = 1'b0;
   logic [7:0]     reg_rdata, protection_flags;
   logic           ramp_done, out_enable, ramp_req, fast_off, low_side_on, temp_comp_enable;
   logic [2:0]     load_line_slope;
   logic [3:0]     current_limit_setpoint;
   logic [MVW-1:0] ovp_thresh_mv, uvp_thresh_mv, pg_low_mv, pg_high_mv;
   int             err_count = 0;
   int             n_tests = 0;
   int             cyc = 0;
   int             n;
   pcfr_top #(.MVW(MVW), .RETRY_CYC(RC)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .setpoint_mv(setpoint_mv), .turn_on_cmd(turn_on_cmd), .ramp_done(ramp_done),
      .ov_det(ov_det), .uv_det(uv_det), .oc_det(oc_det), .ot_det(ot_det), .tr_det(tr_det),
      .flag_clr(flag_clr), .out_enable(out_enable), .ramp_req(ramp_req), .fast_off(fast_off),
      .low_side_on(low_side_on), .load_line_slope(load_line_slope),
      .temp_comp_enable(temp_comp_enable), .current_limit_setpoint(current_limit_setpoint),
      .protection_flags(protection_flags), .ovp_thresh_mv(ovp_thresh_mv),
      .uvp_thresh_mv(uvp_thresh_mv), .pg_low_mv(pg_low_mv), .pg_high_mv(pg_high_mv));
   pcfr_stage_model u_stage (.ref_clk(ref_clk), .rst_n(rst_n), .ramp_req(ramp_req),
      .slow(slow), .ramp_done(ramp_done));
   always #20 ref_clk = ~ref_clk;
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      @(negedge ref_clk);
      chk("rdata", {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic wait_ramp(input int lim);
      n = 1;
      while (ramp_req !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic wait_run;
      n = 0;
      while (!(out_enable === 1'b1 && ramp_req === 1'b0) && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 100) err_count++;
   endtask
   task automatic pulse_clr(input logic [4:0] m);
      @(negedge ref_clk);
      flag_clr = m;
      @(negedge ref_clk);
      flag_clr = 5'h00;
      // Status word trails the flag bits by one edge
      @(negedge ref_clk);
   endtask
   function automatic logic [15:0] pc(input int sp, input int p);
      return 16'((sp * p) / 100);
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      rdc(2'h0, 8'h1B);
      chk("tce", temp_comp_enable, 1'b1);
      rdc(2'h1, 8'h08);
      rdc(2'h2, 8'h43);
      rdc(2'h3, 8'hFF);
      $display("test reset done");
      wr(2'h0, 8'hEF);
      rdc(2'h0, 8'hEB);
      chk("slope", load_line_slope, 3'h7);
      wr(2'h0, 8'h0A);
      rdc(2'h0, 8'h0A);
      chk("tce", temp_comp_enable, 1'b0);
      wr(2'h3, 8'h00);
      rdc(2'h3, 8'hFF);
      $display("test limit done");
      wr(2'h1, 8'hFF);
      rdc(2'h1, 8'h1F);
      chk("pgl", pg_low_mv, pc(1200, 95));
      for (int i = 0; i < 4; i++) begin
         wr(2'h1, 8'(i * 5));
         repeat (2) @(negedge ref_clk);
         chk("ovp", ovp_thresh_mv, pc(1200, i < 2 ? 110 + 10 * i : 130));
         chk("uvp", uvp_thresh_mv, pc(1200, 75 + 5 * i));
         chk("pgl", pg_low_mv, pc(1200, 90));
         chk("pgh", pg_high_mv, pc(1200, 110));
      end
      wr(2'h1, 8'h00);
      setpoint_mv = 12'h320;
      repeat (2) @(negedge ref_clk);
      chk("ovp", ovp_thresh_mv, 16'h03E8);
      chk("uvp", uvp_thresh_mv, pc(800, 75));
      setpoint_mv = 12'h4B0;
      $display("test thresholds done");
      wr(2'h2, 8'hBE);
      rdc(2'h2, 8'hBE);
      wr(2'h2, 8'h00);
      rdc(2'h2, 8'h00);
      slow = 1'b1;
      turn_on_cmd = 1'b1;
      wait_run();
      chk("on", out_enable, 1'b1);
      oc_det = 1'b1;
      @(negedge ref_clk);
      oc_det = 1'b0;
      chk("off", out_enable, 1'b0);
      wait_ramp(200);
      chk("retry", n[15:0], 16'(RC + 2));
      chk("ramp", out_enable, 1'b1);
      chk("ocflag", protection_flags[3], 1'b0);
      pulse_clr(5'h04);
      chk("flags", protection_flags, 8'hFF);
      wait_run();
      slow = 1'b0;
      $display("test retry done");
      wr(2'h2, 8'h02);
      ov_det = 1'b1;
      @(negedge ref_clk);
      ov_det = 1'b0;
      chk("clamp", low_side_on, 1'b1);
      repeat (3 * RC) @(negedge ref_clk);
      chk("latched", {out_enable, ramp_req}, 2'b00);
      pulse_clr(5'h01);
      wait_ramp(5);
      chk("reenable", ramp_req, 1'b1);
      wait_run();
      $display("test latch clear done");
      wr(2'h2, 8'h08);
      slow = 1'b1;
      oc_det = 1'b1;
      @(negedge ref_clk);
      oc_det = 1'b0;
      turn_on_cmd = 1'b0;
      @(negedge ref_clk);
      turn_on_cmd = 1'b1;
      repeat (RC - 6) @(negedge ref_clk);
      chk("early", ramp_req, 1'b0);
      wait_ramp(15);
      chk("recycle", ramp_req, 1'b1);
      $display("test latch recycle done");
      // Long ramp leaves room to show the enable bit gating the tracking trip
      tr_det = 1'b1;
      @(negedge ref_clk);
      chk("trdis", out_enable, 1'b1);
      wr(2'h2, 8'hA0);
      @(negedge ref_clk);
      tr_det = 1'b0;
      chk("trtrip", {out_enable, fast_off}, 2'b01);
      repeat (RC + 5) @(negedge ref_clk);
      chk("trlatch", {out_enable, protection_flags[5]}, 2'b00);
      $display("test tracking done");
      stop_test();
   end
endmodule // testbench

bind pcfr_top pcfr_chk #(.MVW(MVW)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .setpoint_mv(setpoint_mv), .turn_on_cmd(turn_on_cmd), .ov_det(ov_det), .oc_det(oc_det),
   .out_enable(out_enable), .fast_off(fast_off), .low_side_on(low_side_on),
   .current_limit_setpoint(current_limit_setpoint), .protection_flags(protection_flags),
   .ovp_thresh_mv(ovp_thresh_mv), .pg_high_mv(pg_high_mv));
